/* hdl/mrs_pkg.sv */
// Package with operation codes, flag layout, widths and reset values for the execution unit
package mrs_pkg;

  // Data and program widths
  localparam int DATA_W = 8;
  localparam int PWORD_W = 16;
  localparam int PADDR_W = 12;
  localparam int BIT_SEL_W = 3;

  // Flag vector positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_W = 4;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] TABLE_HIGH_BYTE_RST = 8'h00;

  // Constant byte values
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Operation codes presented by the sequencer
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ROT_LEFT_ACC = 5'h01,
    OP_ROT_LEFT_CARRY = 5'h02,
    OP_ROT_LEFT_CARRY_ACC = 5'h03,
    OP_ROT_RIGHT_MEM = 5'h04,
    OP_ROT_RIGHT_ACC = 5'h05,
    OP_ROT_RIGHT_CARRY = 5'h06,
    OP_ROT_RIGHT_CARRY_ACC = 5'h07,
    OP_SUB_BORROW = 5'h08,
    OP_SUB_BORROW_MEM = 5'h09,
    OP_SUB = 5'h0a,
    OP_SUB_MEM = 5'h0b,
    OP_SUB_IMM = 5'h0c,
    OP_DEC_SKIP = 5'h0d,
    OP_DEC_SKIP_ACC = 5'h0e,
    OP_INC_SKIP = 5'h0f,
    OP_INC_SKIP_ACC = 5'h10,
    OP_SKIP_ZERO = 5'h11,
    OP_MOVE_SKIP_ZERO = 5'h12,
    OP_SKIP_BIT_CLEAR = 5'h13,
    OP_SKIP_BIT_SET = 5'h14,
    OP_SET_BYTE = 5'h15,
    OP_SET_BIT = 5'h16,
    OP_SWAP_MEM = 5'h17,
    OP_SWAP_ACC = 5'h18,
    OP_TABLE_CUR = 5'h19,
    OP_TABLE_LAST = 5'h1a,
    OP_XOR = 5'h1b,
    OP_XOR_MEM = 5'h1c,
    OP_XOR_IMM = 5'h1d
  } mrs_op_t;

  // One instruction request from the sequencer
  typedef struct packed {
    mrs_op_t op;
    logic [7:0] mem_data;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } mrs_req_t;

  // Result of the arithmetic/logic stage
  typedef struct packed {
    logic [7:0] value;
    logic [3:0] flags;
    logic [3:0] flag_mask;
    logic to_acc;
    logic to_mem;
    logic skip;
    logic table_op;
  } mrs_res_t;

  // Execution sequence states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_DUMMY = 3'b100
  } mrs_state_t;

endpackage

/* hdl/mrs_sub8.sv */
// Eight-bit subtractor with inverted-borrow carry, half carry and overflow
`timescale 1ns/1ps
module mrs_sub8 (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_in_i,
  output logic [7:0] diff_o,
  output logic carry_o,
  output logic half_carry_o,
  output logic overflow_o
);
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Subtract as a + ~b + c, so carry out is the inverted borrow
  assign full_sum = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, carry_in_i};
  assign low_sum = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, carry_in_i};
  assign diff_o = full_sum[7:0];
  assign carry_o = full_sum[8];
  assign half_carry_o = low_sum[4];
  // Signed overflow: operands differ in sign and result sign follows b
  assign overflow_o = (a_i[7] ^ b_i[7]) & (a_i[7] ^ full_sum[7]);
endmodule

/* hdl/mrs_table_addr.sv */
// Program-memory address former for current-page and last-page table reads
`timescale 1ns/1ps
module mrs_table_addr #(
  parameter int PADDR_W = 12
) (
  input wire logic [PADDR_W-1:0] pc_i,
  input wire logic [7:0] table_pointer_i,
  input wire logic last_page_i,
  output logic [PADDR_W-1:0] addr_o
);
  logic [PADDR_W-9:0] page;

  // Last page is all-ones upper bits; else the page of the running program
  assign page = last_page_i ? {(PADDR_W-8){1'b1}} : pc_i[PADDR_W-1:8];
  assign addr_o = {page, table_pointer_i};
endmodule

/* hdl/mrs_exec_unit.sv */
// Execution unit for rotate, subtract, skip, set, swap, table read and XOR operations
// Overview of operation
// - Rotate left into accumulator, memory kept
// - Rotate memory left through carry
// - Carry rotate left into accumulator only
// - Rotate memory right, flags untouched
// - Rotate right into accumulator, carry unused
// - Carry rotate right, memory or accumulator
// - Subtract with borrow into accumulator
// - Subtract with borrow into memory
// - Carry is inverted borrow on subtract
// - Plain subtract: accumulator, memory, immediate
// - Decrement memory, skip on zero
// - Decrement into accumulator, skip on zero
// - Increment, skip on zero, two forms
// - Skips take two cycles, dummy inserted
// - Skip when memory byte is zero
// - Copy to accumulator, skip if zero
// - Skip on selected bit clear or set
// - Set whole byte or one bit
// - Swap nibbles, memory or accumulator form
// - Current-page table read to memory, high
// - Last-page table read, same otherwise
// - XOR to accumulator or memory, zero only
`timescale 1ns/1ps
module mrs_exec_unit #(
  parameter int PADDR_W = mrs_pkg::PADDR_W
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic issue_i,
  input wire mrs_pkg::mrs_req_t req_i,
  input wire logic [PADDR_W-1:0] pc_i,
  input wire logic [7:0] table_pointer_i,
  input wire logic [15:0] prog_word_i,
  output logic busy_o,
  output logic [7:0] accumulator_o,
  output logic [3:0] flags_o,
  output logic [7:0] table_high_byte_o,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  output logic skip_o,
  output logic prog_re_o,
  output logic [PADDR_W-1:0] prog_addr_o,
  output logic done_o
);
  mrs_pkg::mrs_state_t state_reg;
  mrs_pkg::mrs_state_t state_next;
  logic [7:0] acc_reg;
  logic [3:0] flags_reg;
  logic [7:0] table_high_byte_reg;
  logic mem_we_reg;
  logic [7:0] mem_wdata_reg;
  logic skip_reg;
  logic prog_re_reg;
  logic [PADDR_W-1:0] prog_addr_reg;
  logic done_reg;
  logic table_last_reg;
  logic busy_reg;

  // Decoded operands
  wire mrs_pkg::mrs_op_t op = req_i.op;
  wire [7:0] mem = req_i.mem_data;
  wire carry = flags_reg[mrs_pkg::FLAG_C];
  wire is_imm = (op == mrs_pkg::OP_SUB_IMM) || (op == mrs_pkg::OP_XOR_IMM);
  wire [7:0] operand = is_imm ? req_i.imm : mem;
  wire is_borrow = (op == mrs_pkg::OP_SUB_BORROW) || (op == mrs_pkg::OP_SUB_BORROW_MEM);
  // Plain subtract acts as borrow-free: inverted-borrow input of 1
  wire sub_cin = is_borrow ? carry : 1'b1;

  logic [7:0] diff;
  logic sub_c;
  logic sub_ac;
  logic sub_ov;
  logic [PADDR_W-1:0] tbl_addr;

  // Shared subtractor for all subtract forms
  mrs_sub8 u_sub (
    .a_i(acc_reg),
    .b_i(operand),
    .carry_in_i(sub_cin),
    .diff_o(diff),
    .carry_o(sub_c),
    .half_carry_o(sub_ac),
    .overflow_o(sub_ov)
  );

  // Table address former
  mrs_table_addr #(.PADDR_W(PADDR_W)) u_taddr (
    .pc_i(pc_i),
    .table_pointer_i(table_pointer_i),
    .last_page_i(op == mrs_pkg::OP_TABLE_LAST),
    .addr_o(tbl_addr)
  );

  // Shifted, stepped and masked variants of the memory byte
  wire [7:0] rot_l = {mem[6:0], mem[7]};
  wire [7:0] rot_lc = {mem[6:0], carry};
  wire [7:0] rot_r = {mem[0], mem[7:1]};
  wire [7:0] rot_rc = {carry, mem[7:1]};
  wire [7:0] dec_v = mem - mrs_pkg::ONE_BYTE;
  wire [7:0] inc_v = mem + mrs_pkg::ONE_BYTE;
  wire [7:0] swap_v = {mem[3:0], mem[7:4]};
  wire [7:0] bit_mask = mrs_pkg::ONE_BYTE << req_i.bit_sel;
  wire [7:0] xor_v = acc_reg ^ operand;
  wire sel_bit = |(mem & bit_mask);

  // Result selection; flag_mask marks which flags the operation writes
  mrs_pkg::mrs_res_t res;
  always_comb begin
    res = '0;
    case (op)
      mrs_pkg::OP_ROT_LEFT_ACC: begin
        res.value = rot_l;
        res.to_acc = 1'b1;
      end
      mrs_pkg::OP_ROT_LEFT_CARRY: begin
        res.value = rot_lc;
        res.to_mem = 1'b1;
        res.flags[mrs_pkg::FLAG_C] = mem[7];
        res.flag_mask[mrs_pkg::FLAG_C] = 1'b1;
      end
      mrs_pkg::OP_ROT_LEFT_CARRY_ACC: begin
        res.value = rot_lc;
        res.to_acc = 1'b1;
        res.flags[mrs_pkg::FLAG_C] = mem[7];
        res.flag_mask[mrs_pkg::FLAG_C] = 1'b1;
      end
      mrs_pkg::OP_ROT_RIGHT_MEM: begin
        res.value = rot_r;
        res.to_mem = 1'b1;
      end
      mrs_pkg::OP_ROT_RIGHT_ACC: begin
        res.value = rot_r;
        res.to_acc = 1'b1;
      end
      mrs_pkg::OP_ROT_RIGHT_CARRY, mrs_pkg::OP_ROT_RIGHT_CARRY_ACC: begin
        res.value = rot_rc;
        res.to_mem = (op == mrs_pkg::OP_ROT_RIGHT_CARRY);
        res.to_acc = (op == mrs_pkg::OP_ROT_RIGHT_CARRY_ACC);
        res.flags[mrs_pkg::FLAG_C] = mem[0];
        res.flag_mask[mrs_pkg::FLAG_C] = 1'b1;
      end
      mrs_pkg::OP_SUB_BORROW, mrs_pkg::OP_SUB_BORROW_MEM, mrs_pkg::OP_SUB,
      mrs_pkg::OP_SUB_MEM, mrs_pkg::OP_SUB_IMM: begin
        res.value = diff;
        res.to_mem = (op == mrs_pkg::OP_SUB_BORROW_MEM)
          || (op == mrs_pkg::OP_SUB_MEM);
        res.to_acc = !res.to_mem;
        res.flags[mrs_pkg::FLAG_C] = sub_c;
        res.flags[mrs_pkg::FLAG_AC] = sub_ac;
        res.flags[mrs_pkg::FLAG_OV] = sub_ov;
        res.flags[mrs_pkg::FLAG_Z] = (diff == mrs_pkg::ZERO_BYTE);
        res.flag_mask = 4'hf;
      end
      mrs_pkg::OP_DEC_SKIP, mrs_pkg::OP_DEC_SKIP_ACC: begin
        res.value = dec_v;
        res.to_mem = (op == mrs_pkg::OP_DEC_SKIP);
        res.to_acc = (op == mrs_pkg::OP_DEC_SKIP_ACC);
        res.skip = (dec_v == mrs_pkg::ZERO_BYTE);
      end
      mrs_pkg::OP_INC_SKIP, mrs_pkg::OP_INC_SKIP_ACC: begin
        res.value = inc_v;
        res.to_mem = (op == mrs_pkg::OP_INC_SKIP);
        res.to_acc = (op == mrs_pkg::OP_INC_SKIP_ACC);
        res.skip = (inc_v == mrs_pkg::ZERO_BYTE);
      end
      mrs_pkg::OP_SKIP_ZERO: begin
        res.value = mem;
        res.skip = (mem == mrs_pkg::ZERO_BYTE);
      end
      mrs_pkg::OP_MOVE_SKIP_ZERO: begin
        res.value = mem;
        res.to_acc = 1'b1;
        res.skip = (mem == mrs_pkg::ZERO_BYTE);
      end
      mrs_pkg::OP_SKIP_BIT_CLEAR: begin
        res.value = mem;
        res.skip = !sel_bit;
      end
      mrs_pkg::OP_SKIP_BIT_SET: begin
        res.value = mem;
        res.skip = sel_bit;
      end
      mrs_pkg::OP_SET_BYTE: begin
        res.value = mrs_pkg::ALL_ONES;
        res.to_mem = 1'b1;
      end
      mrs_pkg::OP_SET_BIT: begin
        res.value = mem | bit_mask;
        res.to_mem = 1'b1;
      end
      mrs_pkg::OP_SWAP_MEM, mrs_pkg::OP_SWAP_ACC: begin
        res.value = swap_v;
        res.to_mem = (op == mrs_pkg::OP_SWAP_MEM);
        res.to_acc = (op == mrs_pkg::OP_SWAP_ACC);
      end
      mrs_pkg::OP_TABLE_CUR, mrs_pkg::OP_TABLE_LAST: begin
        res.table_op = 1'b1;
      end
      mrs_pkg::OP_XOR, mrs_pkg::OP_XOR_MEM, mrs_pkg::OP_XOR_IMM: begin
        res.value = xor_v;
        res.to_mem = (op == mrs_pkg::OP_XOR_MEM);
        res.to_acc = !res.to_mem;
        res.flags[mrs_pkg::FLAG_Z] = (xor_v == mrs_pkg::ZERO_BYTE);
        res.flag_mask[mrs_pkg::FLAG_Z] = 1'b1;
      end
      default: begin
        res = '0;
      end
    endcase
  end

  // Instruction accepted only when idle; busy back-pressures the sequencer
  wire take = issue_i && (state_reg == mrs_pkg::ST_IDLE);
  wire skip_take = take && res.skip;
  wire table_take = take && res.table_op;
  wire [3:0] flags_upd = (flags_reg & ~res.flag_mask) | (res.flags & res.flag_mask);

  // Sequencer: skip and table reads take a second cycle
  always_comb begin
    case (state_reg)
      mrs_pkg::ST_IDLE: begin
        if (skip_take) begin
          state_next = mrs_pkg::ST_DUMMY;
        end else if (table_take) begin
          state_next = mrs_pkg::ST_FETCH;
        end else begin
          state_next = mrs_pkg::ST_IDLE;
        end
      end
      mrs_pkg::ST_FETCH: state_next = mrs_pkg::ST_IDLE;
      mrs_pkg::ST_DUMMY: state_next = mrs_pkg::ST_IDLE;
      default: state_next = mrs_pkg::ST_IDLE;
    endcase
  end

  // State and architectural registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= mrs_pkg::ST_IDLE;
      busy_reg <= 1'b0;
      acc_reg <= mrs_pkg::ACC_RST;
      flags_reg <= mrs_pkg::FLAGS_RST;
      table_high_byte_reg <= mrs_pkg::TABLE_HIGH_BYTE_RST;
    end else begin
      state_reg <= state_next;
      // Registered copy so the busy output leaves a flop, not a compare
      busy_reg <= (state_next != mrs_pkg::ST_IDLE);
      if (take && res.to_acc) begin
        acc_reg <= res.value;
      end
      if (take) begin
        flags_reg <= flags_upd;
      end
      // Program word arrives one cycle after the address
      if (state_reg == mrs_pkg::ST_FETCH) begin
        table_high_byte_reg <= prog_word_i[15:8];
      end
    end
  end

  // Output strobes; memory written at most once per instruction
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= mrs_pkg::ZERO_BYTE;
      skip_reg <= 1'b0;
      prog_re_reg <= 1'b0;
      prog_addr_reg <= '0;
      done_reg <= 1'b0;
      table_last_reg <= 1'b0;
    end else begin
      mem_we_reg <= (take && res.to_mem) || (state_reg == mrs_pkg::ST_FETCH);
      mem_wdata_reg <= (state_reg == mrs_pkg::ST_FETCH) ? prog_word_i[7:0] : res.value;
      skip_reg <= skip_take;
      prog_re_reg <= table_take;
      if (table_take) begin
        prog_addr_reg <= tbl_addr;
        table_last_reg <= (op == mrs_pkg::OP_TABLE_LAST);
      end
      done_reg <= (take && !res.skip && !res.table_op) || (state_next == mrs_pkg::ST_IDLE
        && state_reg != mrs_pkg::ST_IDLE);
    end
  end

  assign busy_o = busy_reg;
  assign accumulator_o = acc_reg;
  assign flags_o = flags_reg;
  assign table_high_byte_o = table_high_byte_reg;
  assign mem_we_o = mem_we_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign skip_o = skip_reg;
  assign prog_re_o = prog_re_reg;
  assign prog_addr_o = prog_addr_reg;
  assign done_o = done_reg;
endmodule

/* verif/mrs_exec_unit_properties.sv */
// Port-level checks for the execution unit
`timescale 1ns/1ps
module mrs_exec_unit_properties #(
  parameter int PADDR_W = 12
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic issue_i,
  input wire mrs_pkg::mrs_req_t req_i,
  input wire logic [PADDR_W-1:0] pc_i,
  input wire logic [7:0] table_pointer_i,
  input wire logic [15:0] prog_word_i,
  input wire logic busy_o,
  input wire logic [7:0] accumulator_o,
  input wire logic [3:0] flags_o,
  input wire logic [7:0] table_high_byte_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic skip_o,
  input wire logic prog_re_o,
  input wire logic [PADDR_W-1:0] prog_addr_o,
  input wire logic done_o
);
  // Accepted only while idle; a request during busy is dropped
  wire logic take = issue_i && !busy_o;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_busy_one_cycle: assert property (busy_o |=> !busy_o && done_o)
    else $error("busy not single cycle");
  a_skip_in_dummy: assert property (skip_o |-> busy_o && !done_o)
    else $error("skip pulse outside dummy cycle");
  a_refused_quiet: assert property (busy_o |=>
    $stable(accumulator_o) && $stable(flags_o)) else $error("state moved in dummy cycle");
  a_rot_left_acc: assert property (take && req_i.op == mrs_pkg::OP_ROT_LEFT_ACC |=>
    accumulator_o == {$past(req_i.mem_data[6:0]), $past(req_i.mem_data[7])} &&
    $stable(flags_o) && !mem_we_o) else $error("left rotate to acc wrong");
  a_rot_right_carry: assert property (take &&
    req_i.op == mrs_pkg::OP_ROT_RIGHT_CARRY |=>
    mem_we_o && mem_wdata_o == {$past(flags_o[0]), $past(req_i.mem_data[7:1])} &&
    flags_o[0] == $past(req_i.mem_data[0])) else $error("right carry rotate wrong");
  a_set_byte_ones: assert property (take && req_i.op == mrs_pkg::OP_SET_BYTE |=>
    mem_we_o && mem_wdata_o == 8'hff && $stable(flags_o)) else $error("set byte wrong");
  a_swap_mem: assert property (take && req_i.op == mrs_pkg::OP_SWAP_MEM |=>
    mem_we_o && mem_wdata_o == {$past(req_i.mem_data[3:0]), $past(req_i.mem_data[7:4])})
    else $error("nibble exchange wrong");
  a_last_page_addr: assert property (take && req_i.op == mrs_pkg::OP_TABLE_LAST |=>
    prog_re_o && prog_addr_o[7:0] == $past(table_pointer_i) && &prog_addr_o[PADDR_W-1:8])
    else $error("last page address wrong");
  a_table_load: assert property (prog_re_o |=>
    table_high_byte_o == $past(prog_word_i[15:8]) &&
    mem_we_o && mem_wdata_o == $past(prog_word_i[7:0])) else $error("table bytes wrong");
  a_xor_zero: assert property (take && req_i.op == mrs_pkg::OP_XOR |=>
    flags_o[2] == (accumulator_o == 8'h00) && $stable({flags_o[3], flags_o[1:0]}))
    else $error("xor flags wrong");
  a_sub_carry: assert property (take && req_i.op == mrs_pkg::OP_SUB |=>
    flags_o[0] == ($past(accumulator_o) >= $past(req_i.mem_data))) else $error("borrow wrong");

  c_table: cover property (prog_re_o);
  c_skip: cover property (skip_o);
  c_refused: cover property (busy_o && issue_i);
endmodule

bind mrs_exec_unit mrs_exec_unit_properties #(.PADDR_W(PADDR_W)) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .req_i(req_i),
  .pc_i(pc_i), .table_pointer_i(table_pointer_i), .prog_word_i(prog_word_i),
  .busy_o(busy_o), .accumulator_o(accumulator_o), .flags_o(flags_o),
  .table_high_byte_o(table_high_byte_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
  .skip_o(skip_o), .prog_re_o(prog_re_o), .prog_addr_o(prog_addr_o), .done_o(done_o));

/* verif/mrs_prog_mem.sv */
// Program memory model answering table fetches
`timescale 1ns/1ps
module mrs_prog_mem #(
  parameter int PADDR_W = 12
) (
  input wire logic prog_re_i,
  input wire logic [PADDR_W-1:0] prog_addr_i,
  output logic [15:0] prog_word_o
);
  // Content is a fixed scramble of the address
  wire logic [15:0] word = {prog_addr_i[7:0] ^ 8'h3c, prog_addr_i[PADDR_W-1:PADDR_W-8]};
  // Outside a fetch show the inverse, so a late sample cannot pass
  assign prog_word_o = prog_re_i ? word : ~word;
endmodule

/* verif/tb_mcu_rotate_sub_skip_table_ops.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module tb_mcu_rotate_sub_skip_table_ops;
  logic core_clk_i, rst_n_i, issue_i;
  mrs_pkg::mrs_req_t req_i;
  logic [11:0] pc_i, prog_addr_o;
  logic [7:0] table_pointer_i, accumulator_o, table_high_byte_o, mem_wdata_o;
  logic [15:0] prog_word_i;
  logic [3:0] flags_o;
  logic busy_o, mem_we_o, skip_o, prog_re_o, done_o;
  logic [7:0] e_acc, e_table_high_byte;
  logic [3:0] e_fl;
  logic [31:0] seed;
  int error_cnt, tests_run;

  mrs_exec_unit #(.PADDR_W(12)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .req_i(req_i),
    .pc_i(pc_i), .table_pointer_i(table_pointer_i), .prog_word_i(prog_word_i),
    .busy_o(busy_o), .accumulator_o(accumulator_o), .flags_o(flags_o),
    .table_high_byte_o(table_high_byte_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .skip_o(skip_o), .prog_re_o(prog_re_o), .prog_addr_o(prog_addr_o), .done_o(done_o));
  mrs_prog_mem #(.PADDR_W(12)) u_pmem (
    .prog_re_i(prog_re_o), .prog_addr_i(prog_addr_o), .prog_word_o(prog_word_i));

  always #20 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One instruction; k is the operation encoding, model updated first
  task automatic exec(input int k, input logic [7:0] m, imm, input logic [2:0] b,
                      input logic [11:0] pc, input logic [7:0] tp);
    logic [7:0] v, s;
    logic [8:0] d;
    logic [4:0] h;
    logic cin, sk, two, tab, acc, mem;
    logic [11:0] pa;
    logic [15:0] w;
    cin = (k < 10) ? e_fl[0] : 1'b1;
    s = (k == 12) ? imm : m;
    d = {1'b0, e_acc} + {1'b0, ~s} + {8'h00, cin};
    h = {1'b0, e_acc[3:0]} + {1'b0, ~s[3:0]} + {4'h0, cin};
    v = 8'h00;
    case (k)
      1: v = {m[6:0], m[7]};
      2, 3: v = {m[6:0], e_fl[0]};
      4, 5: v = {m[0], m[7:1]};
      6, 7: v = {e_fl[0], m[7:1]};
      8, 9, 10, 11, 12: v = d[7:0];
      13, 14: v = m - 8'h01;
      15, 16: v = m + 8'h01;
      17, 18: v = m;
      21: v = 8'hff;
      22: v = m | (8'h01 << b);
      23, 24: v = {m[3:0], m[7:4]};
      27, 28: v = e_acc ^ m;
      29: v = e_acc ^ imm;
      default: v = 8'h00;
    endcase
    two = k inside {[13:20]};
    tab = k inside {25, 26};
    sk = two && ((k == 19) ? !m[b] : (k == 20) ? m[b] : (v == 8'h00));
    // Dummy cycle only when the skip is actually taken
    two = sk;
    acc = k inside {1, 3, 5, 7, 8, 10, 12, 14, 16, 18, 24, 27, 29};
    mem = k inside {2, 4, 6, 9, 11, 13, 15, 21, 22, 23, 28};
    pa = {(k == 26) ? 4'hf : pc[11:8], tp};
    w = {pa[7:0] ^ 8'h3c, pa[11:4]};
    if (k inside {2, 3}) e_fl[0] = m[7];
    if (k inside {6, 7}) e_fl[0] = m[0];
    if (k inside {[8:12]}) begin
      e_fl = {(e_acc[7] != s[7]) && (v[7] != e_acc[7]), v == 8'h00, h[4], d[8]};
    end
    if (k inside {[27:29]}) e_fl[2] = (v == 8'h00);
    if (acc) e_acc = v;
    if (tab) e_table_high_byte = w[15:8];
    @(posedge core_clk_i);
    issue_i <= 1'b1;
    req_i <= {mrs_pkg::mrs_op_t'(k), m, imm, b};
    pc_i <= pc;
    table_pointer_i <= tp;
    @(posedge core_clk_i);
    issue_i <= two | tab; // Held on purpose: must be refused while busy
    #1;
    chk("acc", accumulator_o, e_acc);
    chk("flags", flags_o, e_fl);
    chk("mem_we", mem_we_o, mem);
    if (mem) chk("wdata", mem_wdata_o, v);
    chk("skip", skip_o, sk);
    chk("busy", busy_o, two | tab);
    chk("done", done_o, !(two | tab));
    chk("prog_re", prog_re_o, tab);
    if (tab) chk("paddr", prog_addr_o, pa);
    if (two | tab) begin
      @(posedge core_clk_i);
      issue_i <= 1'b0;
      #1;
      chk("done2", done_o, 1'b1);
      chk("busy2", busy_o, 1'b0);
      chk("acc2", accumulator_o, e_acc);
      chk("we2", mem_we_o, tab);
      if (tab) chk("low", mem_wdata_o, w[7:0]);
      chk("table_high_byte", table_high_byte_o, e_table_high_byte);
    end
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(40 * 20000);
    error_cnt++;
    wrap_up();
  end

  // Sweep every operation; early rounds use boundary bytes
  initial begin
    logic [7:0] m;
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    issue_i = 1'b0;
    req_i = '0;
    pc_i = 12'h000;
    table_pointer_i = 8'h00;
    e_acc = 8'h00;
    e_table_high_byte = 8'h00;
    e_fl = 4'h0;
    seed = 32'h46790e7b;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("rst_acc", accumulator_o, 8'h00);
    chk("rst_flags", flags_o, 4'h0);
    chk("rst_table_high_byte", table_high_byte_o, 8'h00);
    chk("rst_busy", busy_o, 1'b0);
    for (int r = 0; r < 8; r++) begin
      for (int k = 1; k < 30; k++) begin
        seed = lfsr(seed);
        m = (r == 0) ? 8'h00 : (r == 1) ? 8'hff : (r == 2) ? 8'h01 : seed[7:0];
        exec(k, m, seed[15:8], seed[18:16], seed[31:20], seed[27:20]);
      end
    end
    wrap_up();
  end
endmodule
